// >>> inc/ldtb_pkg.sv
// Constants shared by the line differential trip block logic.
package ldtb_pkg;
  localparam int AW = 4;
  localparam int DW = 16;
  localparam int IW = 16;
  localparam logic [3:0] OFS_CTRL       = 4'h0;
  localparam logic [3:0] OFS_LOW_THR    = 4'h1;
  localparam logic [3:0] OFS_HIGH_THR   = 4'h2;
  localparam logic [3:0] OFS_MULT       = 4'h3;
  localparam logic [3:0] OFS_TRIP_DELAY = 4'h4;
  localparam logic [3:0] OFS_CT_CORR    = 4'h5;
  localparam logic [3:0] OFS_STATUS     = 4'h6;
  localparam int CTRL_CLK_LSB = 0;
  localparam int CTRL_ELIM    = 4;
  localparam int CTRL_IDMT    = 5;
  localparam int CTRL_TEST    = 6;
  localparam int CTRL_CLEAR   = 7;
  localparam logic [15:0] RST_CTRL       = 16'h0000;
  localparam logic [15:0] RST_LOW_THR    = 16'h0100;
  localparam logic [15:0] RST_HIGH_THR   = 16'h1000;
  localparam logic [15:0] RST_MULT       = 16'h0001;
  localparam logic [15:0] RST_TRIP_DELAY = 16'h0010;
  localparam logic [15:0] RST_CT_CORR    = 16'h1000;
  localparam int CT_FRAC = 12;
  typedef enum logic [1:0] {LS_IDLE, LS_RUN, LS_TRIP} ldtb_ls_t;
endpackage

// >>> verilog/ldtb_core.sv
// Line differential trip block: stage logic, zero-sequence handling and inter-trip.
//
// The strobed register port and the address map were left to the implementer.
`timescale 1ns/1ps
module ldtb_core
(
  // Clock and reset.
  input  wire logic                  CORE_CLK,
  input  wire logic                  NRST,
  // Register port.
  input  wire logic [ldtb_pkg::AW-1:0] REG_ADDR,
  input  wire logic [ldtb_pkg::DW-1:0] REG_WDATA,
  input  wire logic                  REG_WR,
  input  wire logic                  REG_RD,
  output logic [ldtb_pkg::DW-1:0]      REG_RDATA,
  // Binary inputs from pins.
  input  wire logic                  BLOCK_ALL,
  input  wire logic                  LOW_STAGE_INHIBIT,
  input  wire logic                  HIGH_THRESH_MULT_ENABLE,
  // Communication supervision.
  input  wire logic                  COMM_SUPERVISION_OK,
  input  wire logic                  COMM_SUPERVISION_SEVERE,
  // Measurements.
  input  wire logic signed [ldtb_pkg::IW-1:0] LOC_IA,
  input  wire logic signed [ldtb_pkg::IW-1:0] LOC_IB,
  input  wire logic signed [ldtb_pkg::IW-1:0] LOC_IC,
  input  wire logic [ldtb_pkg::IW-1:0] DIFF_AMP,
  // Received from the remote end.
  input  wire logic                  RX_LS_PICKUP,
  input  wire logic                  RX_LS_TRIP,
  input  wire logic                  RX_HS_PICKUP,
  input  wire logic                  RX_HS_TRIP,
  input  wire logic                  RX_TEST,
  input  wire logic signed [ldtb_pkg::IW-1:0] RX_IA,
  input  wire logic signed [ldtb_pkg::IW-1:0] RX_IB,
  input  wire logic signed [ldtb_pkg::IW-1:0] RX_IC,
  // Sent to the remote end.
  output logic                       TX_LS_PICKUP,
  output logic                       TX_LS_TRIP,
  output logic                       TX_HS_PICKUP,
  output logic                       TX_HS_TRIP,
  output logic                       TX_TEST,
  output logic signed [ldtb_pkg::IW-1:0] TX_IA,
  output logic signed [ldtb_pkg::IW-1:0] TX_IB,
  output logic signed [ldtb_pkg::IW-1:0] TX_IC,
  // Corrected local currents and remote sample validity.
  output logic signed [ldtb_pkg::IW-1:0] CORR_IA,
  output logic signed [ldtb_pkg::IW-1:0] CORR_IB,
  output logic signed [ldtb_pkg::IW-1:0] CORR_IC,
  output logic                       REM_SAMPLES_VALID,
  // Stage outputs.
  output logic                       LOW_STAGE_PICKUP_LOCAL,
  output logic                       LOW_STAGE_TRIP_LOCAL,
  output logic                       HIGH_STAGE_PICKUP_LOCAL,
  output logic                       HIGH_STAGE_TRIP_LOCAL,
  output logic                       LOW_STAGE_PICKUP_REMOTE,
  output logic                       LOW_STAGE_TRIP_REMOTE,
  output logic                       HIGH_STAGE_PICKUP_REMOTE,
  output logic                       HIGH_STAGE_TRIP_REMOTE,
  output logic                       TRIP,
  output logic                       PROTECTION_OPERABLE
);

  // Removes one third of the phase sum from a phase current.
  function automatic logic signed [ldtb_pkg::IW-1:0] zs_remove
  (
    input logic signed [ldtb_pkg::IW-1:0] ph,
    input logic signed [ldtb_pkg::IW+1:0] sum
  );
    logic signed [ldtb_pkg::IW+1:0] third;
    third = sum / 18'sd3;
    zs_remove = ph - third[ldtb_pkg::IW-1:0];
  endfunction

  // Scales a sample by the CT correction factor.
  function automatic logic signed [ldtb_pkg::IW-1:0] ct_scale
  (
    input logic signed [ldtb_pkg::IW-1:0] ph,
    input logic [ldtb_pkg::DW-1:0]        k
  );
    logic signed [ldtb_pkg::IW+ldtb_pkg::DW:0] prod;
    prod = ph * $signed({1'b0, k});
    ct_scale = prod[ldtb_pkg::CT_FRAC +: ldtb_pkg::IW];
  endfunction

  // Pin synchroniser, two stages.
  logic [4:0] sync_a;
  logic [4:0] sync_b;
  logic       blk;
  logic       blk_ls;
  logic       mult_en;
  logic       comm_ok;
  logic       comm_severe;

  always_ff @(posedge CORE_CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      sync_a <= 5'h00;
      sync_b <= 5'h00;
    end
    else
    begin
      sync_a <= {COMM_SUPERVISION_SEVERE, COMM_SUPERVISION_OK,
                 HIGH_THRESH_MULT_ENABLE, LOW_STAGE_INHIBIT, BLOCK_ALL};
      sync_b <= sync_a;
    end
  end

  assign blk         = sync_b[0];
  assign blk_ls      = sync_b[1];
  assign mult_en     = sync_b[2];
  assign comm_ok     = sync_b[3];
  assign comm_severe = sync_b[4];

  // Settings registers.
  logic [15:0] ctrl;
  logic [15:0] low_thr;
  logic [15:0] high_thr;
  logic [15:0] mult;
  logic [15:0] trip_delay;
  logic [15:0] ct_corr;
  logic [15:0] rdata;
  logic [15:0] next_ctrl;
  logic [15:0] next_low_thr;
  logic [15:0] next_high_thr;
  logic [15:0] next_mult;
  logic [15:0] next_trip_delay;
  logic [15:0] next_ct_corr;
  logic [15:0] next_rdata;
  logic [15:0] status;
  logic        ls_clear;

  always_comb
  begin
    next_ctrl       = ctrl;
    next_low_thr    = low_thr;
    next_high_thr   = high_thr;
    next_mult       = mult;
    next_trip_delay = trip_delay;
    next_ct_corr    = ct_corr;
    next_rdata      = 16'h0000;
    next_ctrl[ldtb_pkg::CTRL_CLEAR] = 1'b0;
    if (REG_WR)
    begin
      case (REG_ADDR)
        ldtb_pkg::OFS_CTRL:       next_ctrl       = {8'h00, REG_WDATA[7:0]};
        ldtb_pkg::OFS_LOW_THR:    next_low_thr    = REG_WDATA;
        ldtb_pkg::OFS_HIGH_THR:   next_high_thr   = REG_WDATA;
        ldtb_pkg::OFS_MULT:       next_mult       = {8'h00, REG_WDATA[7:0]};
        ldtb_pkg::OFS_TRIP_DELAY: next_trip_delay = REG_WDATA;
        ldtb_pkg::OFS_CT_CORR:    next_ct_corr    = REG_WDATA;
        default:                  next_ctrl       = ctrl & 16'hFF7F;
      endcase
    end
    if (REG_RD)
    begin
      case (REG_ADDR)
        ldtb_pkg::OFS_CTRL:       next_rdata = ctrl;
        ldtb_pkg::OFS_LOW_THR:    next_rdata = low_thr;
        ldtb_pkg::OFS_HIGH_THR:   next_rdata = high_thr;
        ldtb_pkg::OFS_MULT:       next_rdata = mult;
        ldtb_pkg::OFS_TRIP_DELAY: next_rdata = trip_delay;
        ldtb_pkg::OFS_CT_CORR:    next_rdata = ct_corr;
        ldtb_pkg::OFS_STATUS:     next_rdata = status;
        default:                  next_rdata = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge CORE_CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      ctrl       <= ldtb_pkg::RST_CTRL;
      low_thr    <= ldtb_pkg::RST_LOW_THR;
      high_thr   <= ldtb_pkg::RST_HIGH_THR;
      mult       <= ldtb_pkg::RST_MULT;
      trip_delay <= ldtb_pkg::RST_TRIP_DELAY;
      ct_corr    <= ldtb_pkg::RST_CT_CORR;
      rdata      <= 16'h0000;
    end
    else
    begin
      ctrl       <= next_ctrl;
      low_thr    <= next_low_thr;
      high_thr   <= next_high_thr;
      mult       <= next_mult;
      trip_delay <= next_trip_delay;
      ct_corr    <= next_ct_corr;
      rdata      <= next_rdata;
    end
  end

  assign REG_RDATA = rdata;
  assign ls_clear  = ctrl[ldtb_pkg::CTRL_CLEAR];

  // Enables of the two stages.
  logic       test;
  logic       blocked;
  logic       ls_en;
  logic       hs_en;
  logic       ls_cond;
  logic       hs_cond;
  logic [23:0] hs_limit;
  logic [3:0] clk_num;
  logic       zs_auto;

  assign test    = ctrl[ldtb_pkg::CTRL_TEST];
  assign blocked = blk | comm_severe | test;
  assign ls_en   = !blocked && !blk_ls;
  assign hs_en   = !blocked;
  assign hs_limit = mult_en ? 24'(high_thr) * 24'(mult[7:0])
                            : {8'h00, high_thr};
  assign hs_cond = hs_en && ({8'h00, DIFF_AMP} > hs_limit);
  assign ls_cond = ls_en && (DIFF_AMP > low_thr);
  assign clk_num = ctrl[ldtb_pkg::CTRL_CLK_LSB +: 4];
  assign zs_auto = clk_num inside {4'h1, 4'h2, 4'h4, 4'h5,
                                   4'h7, 4'h8, 4'hA, 4'hB};

  // Low stage timer.
  ldtb_pkg::ldtb_ls_t ls_state;
  ldtb_pkg::ldtb_ls_t next_ls_state;
  logic [31:0] acc;
  logic [31:0] next_acc;
  logic [31:0] limit;
  logic [31:0] step;
  logic        idmt;

  assign idmt  = ctrl[ldtb_pkg::CTRL_IDMT];
  assign limit = idmt ? 32'(trip_delay) * 32'(low_thr)
                      : {16'h0000, trip_delay};
  assign step  = idmt ? {16'h0000, DIFF_AMP - low_thr} : 32'h0000_0001;

  always_comb
  begin
    next_ls_state = ls_state;
    next_acc      = acc;
    if (ls_clear || !ls_cond || !comm_ok)
    begin
      next_ls_state = ldtb_pkg::LS_IDLE;
      next_acc      = 32'h0000_0000;
    end
    else
    begin
      case (ls_state)
        ldtb_pkg::LS_IDLE:
        begin
          next_ls_state = ldtb_pkg::LS_RUN;
          next_acc      = 32'h0000_0000;
        end
        ldtb_pkg::LS_RUN:
        begin
          next_acc = acc + step;
          if (next_acc >= limit)
            next_ls_state = ldtb_pkg::LS_TRIP;
        end
        ldtb_pkg::LS_TRIP: next_ls_state = ldtb_pkg::LS_TRIP;
        default:           next_ls_state = ldtb_pkg::LS_IDLE;
      endcase
    end
  end

  always_ff @(posedge CORE_CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      ls_state <= ldtb_pkg::LS_IDLE;
      acc      <= 32'h0000_0000;
    end
    else
    begin
      ls_state <= next_ls_state;
      acc      <= next_acc;
    end
  end

  // Stage and inter-trip outputs.
  logic [13:0] outs;
  logic [13:0] next_outs;
  logic        rem_ok;

  assign rem_ok = !blocked;

  always_comb
  begin
    next_outs     = 14'h0000;
    next_outs[0]  = ls_en && ls_state != ldtb_pkg::LS_IDLE;
    next_outs[1]  = ls_en && ls_state == ldtb_pkg::LS_TRIP;
    next_outs[2]  = hs_cond;
    next_outs[3]  = hs_cond;
    next_outs[4]  = rem_ok && ls_en && RX_LS_PICKUP;
    next_outs[5]  = rem_ok && ls_en && RX_LS_TRIP;
    next_outs[6]  = rem_ok && hs_en && RX_HS_PICKUP;
    next_outs[7]  = rem_ok && hs_en && RX_HS_TRIP;
    if (ls_clear)
      next_outs[7:0] = 8'h00;
    next_outs[8]  = next_outs[1] | next_outs[3]
                  | next_outs[5] | next_outs[7];
    next_outs[9]  = !blk && !test && !comm_severe;
    next_outs[13:10] = next_outs[3:0];
  end

  always_ff @(posedge CORE_CLK or negedge NRST)
  begin
    if (!NRST)
      outs <= 14'h0000;
    else
      outs <= next_outs;
  end

  assign LOW_STAGE_PICKUP_LOCAL   = outs[0];
  assign LOW_STAGE_TRIP_LOCAL     = outs[1];
  assign HIGH_STAGE_PICKUP_LOCAL  = outs[2];
  assign HIGH_STAGE_TRIP_LOCAL    = outs[3];
  assign LOW_STAGE_PICKUP_REMOTE  = outs[4];
  assign LOW_STAGE_TRIP_REMOTE    = outs[5];
  assign HIGH_STAGE_PICKUP_REMOTE = outs[6];
  assign HIGH_STAGE_TRIP_REMOTE   = outs[7];
  assign TRIP                     = outs[8];
  assign PROTECTION_OPERABLE      = outs[9];
  assign TX_LS_PICKUP             = outs[10];
  assign TX_LS_TRIP               = outs[11];
  assign TX_HS_PICKUP             = outs[12];
  assign TX_HS_TRIP               = outs[13];
  assign status = {6'h00, ls_state, outs[9], comm_severe, comm_ok,
                   RX_TEST, outs[3:0]};

  // Zero-sequence removal, scaling and echo path.
  logic signed [ldtb_pkg::IW+1:0] sum;
  logic signed [ldtb_pkg::IW-1:0] cor [3];
  logic signed [ldtb_pkg::IW-1:0] next_cor [3];
  logic signed [ldtb_pkg::IW-1:0] tx [3];
  logic signed [ldtb_pkg::IW-1:0] next_tx [3];
  logic signed [ldtb_pkg::IW-1:0] loc [3];
  logic signed [ldtb_pkg::IW-1:0] rx [3];
  logic                       tx_test;
  logic                       rem_valid;

  assign loc[0] = LOC_IA;
  assign loc[1] = LOC_IB;
  assign loc[2] = LOC_IC;
  assign rx[0]  = RX_IA;
  assign rx[1]  = RX_IB;
  assign rx[2]  = RX_IC;
  assign sum    = 18'(LOC_IA) + 18'(LOC_IB) + 18'(LOC_IC);

  always_comb
  begin
    for (int i = 0; i < 3; i++)
    begin
      if (zs_auto || ctrl[ldtb_pkg::CTRL_ELIM])
        next_cor[i] = zs_remove(loc[i], sum);
      else
        next_cor[i] = loc[i];
      if (RX_TEST && !test)
        next_tx[i] = -rx[i];
      else
        next_tx[i] = ct_scale(loc[i], ct_corr);
    end
  end

  always_ff @(posedge CORE_CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      for (int i = 0; i < 3; i++)
      begin
        cor[i] <= '0;
        tx[i]  <= '0;
      end
      tx_test   <= 1'b0;
      rem_valid <= 1'b0;
    end
    else
    begin
      for (int i = 0; i < 3; i++)
      begin
        cor[i] <= next_cor[i];
        tx[i]  <= next_tx[i];
      end
      tx_test   <= test;
      rem_valid <= !RX_TEST;
    end
  end

  assign CORR_IA           = cor[0];
  assign CORR_IB           = cor[1];
  assign CORR_IC           = cor[2];
  assign TX_IA             = tx[0];
  assign TX_IB             = tx[1];
  assign TX_IC             = tx[2];
  assign TX_TEST           = tx_test;
  assign REM_SAMPLES_VALID = rem_valid;

  // Checks on the stage behaviour.
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!NRST);

  chk_block_kills_outs: assert property (blk |=> !TRIP && !TX_LS_TRIP && !TX_HS_TRIP)
    else $error("Trip active while blocked.");
  chk_operable_level: assert property (1'b1 |=> PROTECTION_OPERABLE == $past(!blk && !test && !comm_severe))
    else $error("Operable output wrong.");
  chk_ls_pickup_run: assert property (ls_state == ldtb_pkg::LS_RUN && ls_en && !ls_clear
    |=> LOW_STAGE_PICKUP_LOCAL)
    else $error("Low pickup missing while timer runs.");
  chk_comm_loss_reset: assert property (!comm_ok |=> ls_state == ldtb_pkg::LS_IDLE)
    else $error("Timer not reset on channel loss.");
  chk_dt_trip_delay: assert property (!idmt && trip_delay == 16'h0004 && ls_cond && comm_ok
    && ls_state == ldtb_pkg::LS_IDLE && !ls_clear ##1 (ls_cond && comm_ok && !idmt
    && !ls_clear)[*4] |=> ls_state == ldtb_pkg::LS_TRIP)
    else $error("DT timer did not trip at delay.");
  chk_hs_instant: assert property (hs_cond && !ls_clear |=> HIGH_STAGE_TRIP_LOCAL)
    else $error("High stage did not trip.");
  chk_trip_or: assert property (TRIP == (LOW_STAGE_TRIP_LOCAL | HIGH_STAGE_TRIP_LOCAL
    | LOW_STAGE_TRIP_REMOTE | HIGH_STAGE_TRIP_REMOTE))
    else $error("Combined trip is not the OR.");
  chk_ls_inhibit: assert property (blk_ls |=> !LOW_STAGE_TRIP_LOCAL && !LOW_STAGE_TRIP_REMOTE)
    else $error("Low stage active while inhibited.");
  chk_test_no_tx: assert property (test |=> TX_TEST && !TX_LS_PICKUP && !TX_HS_PICKUP)
    else $error("Inter-trip sent in test mode.");
  chk_severe_block: assert property (comm_severe |=> !HIGH_STAGE_TRIP_LOCAL)
    else $error("Stage active under severe interference.");

  cov_ls_trip: cover property (ls_state == ldtb_pkg::LS_RUN ##1 ls_state == ldtb_pkg::LS_TRIP);
  cov_hs_trip: cover property (HIGH_STAGE_TRIP_LOCAL && mult_en);
  cov_rem_trip: cover property (LOW_STAGE_TRIP_REMOTE);
  cov_echo: cover property (RX_TEST && !test);

endmodule

// >>> tb/ldtb_remote_model.sv
// Behavioural model of the remote relay across the protection channel.
`timescale 1ns/1ps
module ldtb_remote_model
#(
  // Own sample value; arbitrary.
  parameter logic signed [15:0] OWN_I = 16'sh0123
)
(
  // Clock and reset.
  input  wire logic               clk,
  input  wire logic               nrst,
  // Bench commands.
  input  wire logic               cmd_ls_trip,
  input  wire logic               cmd_hs_trip,
  input  wire logic               cmd_test,
  input  wire logic               cmd_slow,
  // From the local end.
  input  wire logic               tx_test,
  input  wire logic signed [15:0] tx_ia,
  input  wire logic signed [15:0] tx_ib,
  input  wire logic signed [15:0] tx_ic,
  // To the local end.
  output logic [4:0]              rx_sig,
  output logic signed [15:0]      rx_ia,
  output logic signed [15:0]      rx_ib,
  output logic signed [15:0]      rx_ic
);
  logic [4:0]         next_sig;
  logic [4:0]         sig;
  logic [4:0]         late;
  logic signed [15:0] next_ia;
  logic signed [15:0] next_ib;
  logic signed [15:0] next_ic;
  logic               echo;
  always_comb
  begin
    // Own pickups and trips go out unless this end tests.
    next_sig = {cmd_test, {4{!cmd_test}} & {cmd_hs_trip, cmd_hs_trip, cmd_ls_trip, cmd_ls_trip}};
    // A testing local end gets its samples back inverted unless this end tests too.
    // Samples from a testing end are not used by this end.
    echo = tx_test && !cmd_test;
    next_ia = echo ? -tx_ia : OWN_I;
    next_ib = echo ? -tx_ib : OWN_I;
    next_ic = echo ? -tx_ic : OWN_I;
  end
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      sig   <= 5'h00;
      late  <= 5'h00;
      rx_ia <= 16'sh0000;
      rx_ib <= 16'sh0000;
      rx_ic <= 16'sh0000;
    end
    else
    begin
      sig   <= next_sig;
      late  <= sig;
      rx_ia <= next_ia;
      rx_ib <= next_ib;
      rx_ic <= next_ic;
    end
  end
  // A slow channel delivers the signals one cycle later.
  assign rx_sig = cmd_slow ? late : sig;
endmodule

// >>> tb/line_diff_trip_block_logic_tb.sv
// Self-checking bench for the line differential trip block logic.
`timescale 1ns/1ps
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin failures++; \
  $display("MISMATCH %s expected %0h seen %0h", n, e, g); end end
module line_diff_trip_block_logic_tb;
  logic CORE_CLK = 1'b0, NRST = 1'b0, REG_WR = 1'b0, REG_RD = 1'b0;
  logic [3:0] REG_ADDR = 4'h0;
  logic [15:0] REG_WDATA = 16'h0000, DIFF_AMP = 16'h0000, REG_RDATA;
  logic BLOCK_ALL = 1'b0, LOW_STAGE_INHIBIT = 1'b0, HIGH_THRESH_MULT_ENABLE = 1'b0;
  logic COMM_SUPERVISION_OK = 1'b1, COMM_SUPERVISION_SEVERE = 1'b0;
  logic signed [15:0] LOC_IA = 16'sh0000, LOC_IB = 16'sh0000, LOC_IC = 16'sh0000;
  logic signed [15:0] RX_IA, RX_IB, RX_IC, TX_IA, TX_IB, TX_IC, CORR_IA, CORR_IB, CORR_IC;
  logic RX_LS_PICKUP, RX_LS_TRIP, RX_HS_PICKUP, RX_HS_TRIP, RX_TEST;
  logic TX_LS_PICKUP, TX_LS_TRIP, TX_HS_PICKUP, TX_HS_TRIP, TX_TEST, REM_SAMPLES_VALID;
  logic LOW_STAGE_PICKUP_LOCAL, LOW_STAGE_TRIP_LOCAL, HIGH_STAGE_PICKUP_LOCAL;
  logic HIGH_STAGE_TRIP_LOCAL, LOW_STAGE_PICKUP_REMOTE, LOW_STAGE_TRIP_REMOTE;
  logic HIGH_STAGE_PICKUP_REMOTE, HIGH_STAGE_TRIP_REMOTE, TRIP, PROTECTION_OPERABLE;
  logic cmd_ls_trip = 1'b0, cmd_hs_trip = 1'b0, cmd_test = 1'b0, cmd_slow = 1'b0;
  int failures = 0, cmp_count = 0, n, t1;

  ldtb_core u_ldtb_core
  (
    .CORE_CLK, .NRST, .REG_ADDR, .REG_WDATA, .REG_WR, .REG_RD, .REG_RDATA, .BLOCK_ALL,
    .LOW_STAGE_INHIBIT, .HIGH_THRESH_MULT_ENABLE, .COMM_SUPERVISION_OK,
    .COMM_SUPERVISION_SEVERE, .LOC_IA, .LOC_IB, .LOC_IC, .DIFF_AMP, .RX_LS_PICKUP,
    .RX_LS_TRIP, .RX_HS_PICKUP, .RX_HS_TRIP, .RX_TEST, .RX_IA, .RX_IB, .RX_IC,
    .TX_LS_PICKUP, .TX_LS_TRIP, .TX_HS_PICKUP, .TX_HS_TRIP, .TX_TEST, .TX_IA, .TX_IB,
    .TX_IC, .CORR_IA, .CORR_IB, .CORR_IC, .REM_SAMPLES_VALID, .LOW_STAGE_PICKUP_LOCAL,
    .LOW_STAGE_TRIP_LOCAL, .HIGH_STAGE_PICKUP_LOCAL, .HIGH_STAGE_TRIP_LOCAL,
    .LOW_STAGE_PICKUP_REMOTE, .LOW_STAGE_TRIP_REMOTE, .HIGH_STAGE_PICKUP_REMOTE,
    .HIGH_STAGE_TRIP_REMOTE, .TRIP, .PROTECTION_OPERABLE
  );
  ldtb_remote_model u_ldtb_remote_model
  (
    .clk(CORE_CLK), .nrst(NRST), .cmd_ls_trip, .cmd_hs_trip, .cmd_test, .cmd_slow,
    .tx_test(TX_TEST), .tx_ia(TX_IA), .tx_ib(TX_IB), .tx_ic(TX_IC),
    .rx_sig({RX_TEST, RX_HS_TRIP, RX_HS_PICKUP, RX_LS_TRIP, RX_LS_PICKUP}),
    .rx_ia(RX_IA), .rx_ib(RX_IB), .rx_ic(RX_IC)
  );

  always #2.5 CORE_CLK = ~CORE_CLK;

  task automatic wt(input int c);
    repeat (c) @(posedge CORE_CLK);
    #1;
  endtask
  task automatic reg_wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge CORE_CLK);
    REG_WR <= 1'b1;
    REG_ADDR <= a;
    REG_WDATA <= d;
    @(posedge CORE_CLK);
    REG_WR <= 1'b0;
  endtask
  task automatic reg_chk(input logic [3:0] a, input logic [15:0] e);
    @(posedge CORE_CLK);
    REG_RD <= 1'b1;
    REG_ADDR <= a;
    @(posedge CORE_CLK);
    REG_RD <= 1'b0;
    #1;
    `CHK("reg_rdata", e, REG_RDATA)
  endtask
  task automatic set_ctrl(input logic [3:0] k, input logic e, input logic i, input logic t);
    reg_wr(ldtb_pkg::OFS_CTRL, {9'h000, t, i, e, k});
  endtask
  task automatic wait_sig(input int s, output int c);
    c = 0;
    while (c < 80 && (s == 0 ? LOW_STAGE_PICKUP_LOCAL : LOW_STAGE_TRIP_LOCAL) !== 1'b1)
    begin
      wt(1);
      c++;
    end
  endtask
  // Runs the low stage at one amplitude and returns pickup-to-trip cycles.
  task automatic lo_run(input logic [15:0] amp, output int t);
    int p;
    @(posedge CORE_CLK);
    DIFF_AMP <= amp;
    wait_sig(0, p);
    `CHK("ls_pickup_time", 1'b1, p <= 3)
    wait_sig(1, t);
    wt(1);
    `CHK("trip_low", 1'b1, TRIP)
    `CHK("tx_ls_trip", 1'b1, TX_LS_TRIP)
    @(posedge CORE_CLK);
    DIFF_AMP <= 16'h0000;
    wt(4);
    `CHK("ls_pickup_drop", 1'b0, LOW_STAGE_PICKUP_LOCAL)
    `CHK("ls_trip_drop", 1'b0, LOW_STAGE_TRIP_LOCAL)
  endtask

  task automatic t_regs();
    reg_chk(ldtb_pkg::OFS_CTRL, ldtb_pkg::RST_CTRL);
    reg_chk(ldtb_pkg::OFS_LOW_THR, ldtb_pkg::RST_LOW_THR);
    reg_chk(ldtb_pkg::OFS_HIGH_THR, ldtb_pkg::RST_HIGH_THR);
    reg_chk(ldtb_pkg::OFS_MULT, ldtb_pkg::RST_MULT);
    reg_chk(ldtb_pkg::OFS_TRIP_DELAY, ldtb_pkg::RST_TRIP_DELAY);
    reg_chk(ldtb_pkg::OFS_CT_CORR, ldtb_pkg::RST_CT_CORR);
    reg_chk(ldtb_pkg::OFS_STATUS, 16'h00A0);
    reg_wr(4'hF, 16'hFFFF);
    reg_chk(4'hF, 16'h0000);
  endtask
  task automatic t_zero();
    logic rm;
    @(posedge CORE_CLK);
    LOC_IA <= 16'sh012C;
    for (int k = 0; k < 12; k++)
    begin
      for (int e = 0; e < 2; e++)
      begin
        set_ctrl(4'(k), 1'(e), 1'b0, 1'b0);
        wt(3);
        rm = (e == 1) || (k inside {1, 2, 4, 5, 7, 8, 10, 11});
        `CHK("corr_ia", rm ? 16'sh00C8 : 16'sh012C, CORR_IA)
        `CHK("corr_ib", rm ? 16'shFF9C : 16'sh0000, CORR_IB)
        `CHK("corr_ic", rm ? 16'shFF9C : 16'sh0000, CORR_IC)
      end
    end
    set_ctrl(4'h0, 1'b0, 1'b0, 1'b0);
  endtask
  task automatic t_high();
    reg_wr(ldtb_pkg::OFS_MULT, 16'h0002);
    @(posedge CORE_CLK);
    DIFF_AMP <= 16'h1000;
    wt(3);
    `CHK("hs_at_limit", 1'b0, HIGH_STAGE_TRIP_LOCAL)
    @(posedge CORE_CLK);
    DIFF_AMP <= 16'h1001;
    wt(3);
    `CHK("hs_trip", 1'b1, HIGH_STAGE_TRIP_LOCAL)
    `CHK("hs_pickup", 1'b1, HIGH_STAGE_PICKUP_LOCAL)
    `CHK("trip_high", 1'b1, TRIP)
    `CHK("tx_hs_trip", 1'b1, TX_HS_TRIP)
    @(posedge CORE_CLK);
    HIGH_THRESH_MULT_ENABLE <= 1'b1;
    DIFF_AMP <= 16'h2000;
    wt(6);
    `CHK("hs_mult_limit", 1'b0, HIGH_STAGE_TRIP_LOCAL)
    @(posedge CORE_CLK);
    DIFF_AMP <= 16'h2001;
    wt(3);
    `CHK("hs_mult_trip", 1'b1, HIGH_STAGE_TRIP_LOCAL)
    @(posedge CORE_CLK);
    HIGH_THRESH_MULT_ENABLE <= 1'b0;
    DIFF_AMP <= 16'h0000;
    wt(6);
  endtask
  task automatic t_low();
    reg_wr(ldtb_pkg::OFS_TRIP_DELAY, 16'h0008);
    lo_run(16'h0200, t1);
    `CHK("dt_delay", 8, t1)
    lo_run(16'h0200, t1);
    `CHK("dt_restart", 8, t1)
    set_ctrl(4'h0, 1'b0, 1'b1, 1'b0);
    reg_wr(ldtb_pkg::OFS_TRIP_DELAY, 16'h0004);
    lo_run(16'h0300, t1);
    lo_run(16'h0180, n);
    `CHK("idmt_spread", 6, n - t1)
    set_ctrl(4'h0, 1'b0, 1'b0, 1'b0);
  endtask
  task automatic t_block();
    @(posedge CORE_CLK);
    DIFF_AMP <= 16'h1800;
    cmd_ls_trip <= 1'b1;
    cmd_hs_trip <= 1'b1;
    wt(4);
    `CHK("rem_ls_trip", 1'b1, LOW_STAGE_TRIP_REMOTE)
    `CHK("rem_ls_pickup", 1'b1, LOW_STAGE_PICKUP_REMOTE)
    `CHK("rem_hs_trip", 1'b1, HIGH_STAGE_TRIP_REMOTE)
    `CHK("rem_hs_pickup", 1'b1, HIGH_STAGE_PICKUP_REMOTE)
    reg_wr(ldtb_pkg::OFS_CTRL, 16'h0080);
    wt(1);
    `CHK("clr_hs_trip", 1'b0, HIGH_STAGE_TRIP_LOCAL)
    `CHK("clr_trip", 1'b0, TRIP)
    @(posedge CORE_CLK);
    LOW_STAGE_INHIBIT <= 1'b1;
    wt(6);
    `CHK("inh_ls_pickup", 1'b0, LOW_STAGE_PICKUP_LOCAL)
    `CHK("inh_rem_ls", 1'b0, LOW_STAGE_TRIP_REMOTE)
    `CHK("inh_hs_trip", 1'b1, HIGH_STAGE_TRIP_LOCAL)
    `CHK("inh_rem_hs", 1'b1, HIGH_STAGE_TRIP_REMOTE)
    `CHK("inh_operable", 1'b1, PROTECTION_OPERABLE)
    @(posedge CORE_CLK);
    LOW_STAGE_INHIBIT <= 1'b0;
    BLOCK_ALL <= 1'b1;
    wt(6);
    `CHK("blk_trip", 1'b0, TRIP)
    `CHK("blk_rem_hs", 1'b0, HIGH_STAGE_TRIP_REMOTE)
    `CHK("blk_tx_hs", 1'b0, TX_HS_TRIP)
    `CHK("blk_operable", 1'b0, PROTECTION_OPERABLE)
    `CHK("blk_corr", 16'sh012C, CORR_IA)
    @(posedge CORE_CLK);
    BLOCK_ALL <= 1'b0;
    COMM_SUPERVISION_SEVERE <= 1'b1;
    wt(6);
    `CHK("sev_trip", 1'b0, TRIP)
    `CHK("sev_operable", 1'b0, PROTECTION_OPERABLE)
    @(posedge CORE_CLK);
    COMM_SUPERVISION_SEVERE <= 1'b0;
    COMM_SUPERVISION_OK <= 1'b0;
    DIFF_AMP <= 16'h0200;
    cmd_ls_trip <= 1'b0;
    cmd_hs_trip <= 1'b0;
    wt(20);
    `CHK("int_no_trip", 1'b0, LOW_STAGE_TRIP_LOCAL)
    @(posedge CORE_CLK);
    COMM_SUPERVISION_OK <= 1'b1;
    DIFF_AMP <= 16'h0000;
    wt(6);
  endtask
  task automatic t_test();
    reg_wr(ldtb_pkg::OFS_CT_CORR, 16'h0800);
    @(posedge CORE_CLK);
    LOC_IA <= 16'sh0190;
    DIFF_AMP <= 16'h1800;
    cmd_hs_trip <= 1'b1;
    cmd_slow <= 1'b1;
    set_ctrl(4'h0, 1'b0, 1'b0, 1'b1);
    wt(6);
    `CHK("tst_tx_test", 1'b1, TX_TEST)
    `CHK("tst_tx_ia", 16'sh00C8, TX_IA)
    `CHK("tst_operable", 1'b0, PROTECTION_OPERABLE)
    `CHK("tst_hs_trip", 1'b0, HIGH_STAGE_TRIP_LOCAL)
    `CHK("tst_rem_hs", 1'b0, HIGH_STAGE_TRIP_REMOTE)
    `CHK("tst_tx_hs", 1'b0, TX_HS_TRIP)
    `CHK("tst_trip", 1'b0, TRIP)
    set_ctrl(4'h0, 1'b0, 1'b0, 1'b0);
    @(posedge CORE_CLK);
    cmd_test <= 1'b1;
    wt(6);
    `CHK("rem_valid", 1'b0, REM_SAMPLES_VALID)
    `CHK("echo_ia", 16'shFEDD, TX_IA)
    `CHK("rt_operable", 1'b1, PROTECTION_OPERABLE)
    `CHK("rt_hs_trip", 1'b1, HIGH_STAGE_TRIP_LOCAL)
    @(posedge CORE_CLK);
    cmd_test <= 1'b0;
    cmd_hs_trip <= 1'b0;
    DIFF_AMP <= 16'h0000;
    wt(4);
  endtask

  task automatic report_and_stop();
    $display("Comparisons %0d, failures %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial
  begin
    repeat (20) @(posedge CORE_CLK);
    NRST <= 1'b1;
    wt(3);
    t_regs();
    t_zero();
    t_high();
    t_low();
    t_block();
    t_test();
    report_and_stop();
  end
  initial
  begin
    repeat (20000) @(posedge CORE_CLK);
    failures++;
    report_and_stop();
  end
endmodule
